/* rtl/astg_gate.sv */
// Purpose: acquisition start trigger gate ahead of frame start
// Assumes: frame_trig_in is a one-cycle frame start request
// Notes:   registers on Avalon-MM, one wait state per access
`timescale 1ns/100ps
`default_nettype none

`include "astg_regs.svh"

// Operation
// - switching the gate on while armed enters waiting-for-acquisition-start
// - frame triggers are discarded while waiting for acquisition start
// - start trigger moves to frame wait; each frame trigger exposes
// - count accepted frames; at burst length return to waiting state
// - counting and return apply only with start trigger mode on
// - with mode off start triggers are generated internally
// - with software selected, each software trigger command is one start trigger
// - with line 1 selected, start triggers come from line 1
// - polarity picks rising or falling edge of the line
// - start trigger source resets to input line 2
// - burst length accepts 1 through 255
// - start triggers act only in waiting-for-acquisition-start
// - gating only in standard mode; legacy mode after reset
module astg_gate
  import astg_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        line1_in,
  input  wire logic        line2_in,
  input  wire logic        frame_trig_in,
  output logic             frame_start_ok,
  output logic             wait_acq,
  output logic             wait_frame
);

  astg_ctrl_t  ctrl;
  logic [7:0]  fcount;
  astg_cmd_t   cmd;
  astg_state_t state;
  logic [7:0]  frame_cnt;
  logic        served;
  logic        req;
  logic        wr_take;
  logic        gate_on;
  logic        gate_on_q;
  logic        gate_rise;
  logic        line1_pulse;
  logic        line2_pulse;
  logic        acq_trig;
  logic        frame_acc;
  logic        burst_done;
  logic        wrote_ctrl;

  // decode one register offset
  function automatic logic hit(input logic [3:0] adr,
                               input logic [3:0] ofs);
    hit = (adr == ofs);
  endfunction : hit

  // bus handshake: first cycle waits, second answers
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~served;
  assign wr_take         = avs_write & served;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      served <= 1'b0;
    end else begin
      served <= req & ~served;
    end
  end

  // control register; std mode off gives legacy behaviour
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl.std_mode <= 1'b0;
      ctrl.trig_on  <= 1'b0;
      ctrl.act_fall <= 1'b0;
      ctrl.src      <= SRC_LINE2;
    end else if (wr_take && hit(avs_address, `ASTG_OFS_CTRL)
                 && avs_byteenable[0]) begin
      ctrl.std_mode <= avs_writedata[`ASTG_CTRL_STD];
      ctrl.trig_on  <= avs_writedata[`ASTG_CTRL_TRIG_ON];
      ctrl.act_fall <= avs_writedata[`ASTG_CTRL_FALL];
      ctrl.src      <= astg_src_t'(
        avs_writedata[`ASTG_CTRL_SRC_HI:`ASTG_CTRL_SRC_LO]);
    end
  end

  // burst length; zero is refused so the count can always end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fcount <= `ASTG_FCOUNT_RST;
    end else if (wr_take && hit(avs_address, `ASTG_OFS_FCOUNT)
                 && avs_byteenable[0]
                 && avs_writedata[7:0] >= `ASTG_FCOUNT_MIN) begin
      fcount <= avs_writedata[7:0];
    end
  end

  // command strobes last the one cycle the write is taken
  always_comb begin
    cmd = '0;
    if (wr_take && hit(avs_address, `ASTG_OFS_CMD)
        && avs_byteenable[0]) begin
      cmd.sw_trig   = avs_writedata[`ASTG_CMD_SWTRIG];
      cmd.acq_start = avs_writedata[`ASTG_CMD_START];
      cmd.acq_stop  = avs_writedata[`ASTG_CMD_STOP];
    end
  end

  // read data loaded in the wait cycle, stands at the answer edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !served) begin
      avs_readdata <= 32'h0000_0000;
      if (hit(avs_address, `ASTG_OFS_CTRL)) begin
        avs_readdata[`ASTG_CTRL_STD]     <= ctrl.std_mode;
        avs_readdata[`ASTG_CTRL_TRIG_ON] <= ctrl.trig_on;
        avs_readdata[`ASTG_CTRL_FALL]    <= ctrl.act_fall;
        avs_readdata[`ASTG_CTRL_SRC_HI:`ASTG_CTRL_SRC_LO] <= ctrl.src;
      end else if (hit(avs_address, `ASTG_OFS_FCOUNT)) begin
        avs_readdata[7:0] <= fcount;
      end else if (hit(avs_address, `ASTG_OFS_STATUS)) begin
        avs_readdata[`ASTG_STAT_WAIT_ACQ] <= (state == ST_WAIT_ACQ);
        avs_readdata[`ASTG_STAT_WAIT_FRM] <= (state == ST_WAIT_FRAME);
        avs_readdata[`ASTG_STAT_ARMED]    <= (state != ST_IDLE);
        avs_readdata[`ASTG_STAT_CNT_HI:`ASTG_STAT_CNT_LO] <= frame_cnt;
      end
    end
  end

  // external lines: synchronised, selected edge as one pulse
  astg_edge_det u_line1 (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .line_in    (line1_in),
    .fall_sel   (ctrl.act_fall),
    .edge_pulse (line1_pulse)
  );

  astg_edge_det u_line2 (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .line_in    (line2_in),
    .fall_sel   (ctrl.act_fall),
    .edge_pulse (line2_pulse)
  );

  // gating is live only in standard mode with trigger mode on
  assign gate_on   = ctrl.std_mode & ctrl.trig_on;
  assign gate_rise = gate_on & ~gate_on_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_on_q <= 1'b0;
    end else begin
      gate_on_q <= gate_on;
    end
  end

  // start trigger from the selected source
  always_comb begin
    unique case (ctrl.src)
      SRC_SOFTWARE: acq_trig = cmd.sw_trig;
      SRC_LINE1:    acq_trig = line1_pulse;
      SRC_LINE2:    acq_trig = line2_pulse;
      default:      acq_trig = 1'b0;
    endcase
  end

  // only the frame-waiting state lets a frame trigger through
  assign frame_acc  = frame_trig_in && state == ST_WAIT_FRAME;
  assign burst_done = frame_acc && gate_on
                      && (frame_cnt == fcount - 8'h01);

  // gate state; stop beats everything, a gate switch-on beats start
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else if (cmd.acq_stop) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (cmd.acq_start) begin
            state <= ST_WAIT_ACQ;
          end
        end
        ST_WAIT_ACQ: begin
          if (!gate_on) begin
            state <= ST_WAIT_FRAME;
          end else if (!gate_rise && acq_trig) begin
            state <= ST_WAIT_FRAME;
          end
        end
        ST_WAIT_FRAME: begin
          if (gate_rise || burst_done) begin
            state <= ST_WAIT_ACQ;
          end
        end
      endcase
    end
  end

  // frames accepted since the last start trigger
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt <= 8'h00;
    end else if (state != ST_WAIT_FRAME || gate_rise || burst_done
                 || !gate_on) begin
      frame_cnt <= 8'h00;
    end else if (frame_acc) begin
      frame_cnt <= frame_cnt + 8'h01;
    end
  end

  // registered outputs towards exposure control
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_start_ok <= 1'b0;
      wait_acq       <= 1'b0;
      wait_frame     <= 1'b0;
    end else begin
      frame_start_ok <= frame_acc;
      wait_acq       <= (state == ST_WAIT_ACQ);
      wait_frame     <= (state == ST_WAIT_FRAME);
    end
  end

  // remembers whether software has touched the control register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrote_ctrl <= 1'b0;
    end else if (wr_take && hit(avs_address, `ASTG_OFS_CTRL)) begin
      wrote_ctrl <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_gate_on_wait:
    assert property (gate_rise && state == ST_WAIT_FRAME
                     && !cmd.acq_stop |=> state == ST_WAIT_ACQ)
    else $error("gate switch-on did not wait for start");

  a_discard_frame:
    assert property (state == ST_WAIT_ACQ && frame_trig_in
                     |=> !frame_start_ok)
    else $error("frame passed while waiting for start");

  a_start_moves:
    assert property (state == ST_WAIT_ACQ && gate_on && !gate_rise
                     && acq_trig && !cmd.acq_stop
                     |=> state == ST_WAIT_FRAME ##1 wait_frame)
    else $error("start trigger not taken");

  a_frame_passes:
    assert property (state == ST_WAIT_FRAME && frame_trig_in
                     |=> frame_start_ok)
    else $error("frame trigger lost in frame wait");

  a_burst_return:
    assert property (state == ST_WAIT_FRAME && gate_on && frame_acc
                     && frame_cnt + 8'h01 == fcount && !cmd.acq_stop
                     |=> state == ST_WAIT_ACQ && frame_cnt == 8'h00)
    else $error("burst end did not return to wait");

  a_no_count_off:
    assert property (state == ST_WAIT_FRAME && !gate_on
                     && !cmd.acq_stop
                     |=> state == ST_WAIT_FRAME && frame_cnt == 8'h00)
    else $error("counting while trigger mode off");

  a_off_internal:
    assert property (state == ST_WAIT_ACQ && !gate_on && !cmd.acq_stop
                     |=> state == ST_WAIT_FRAME)
    else $error("no internal start with mode off");

  a_sw_start:
    assert property (state == ST_WAIT_ACQ && gate_on && !gate_rise
                     && ctrl.src == SRC_SOFTWARE && cmd.sw_trig
                     && !cmd.acq_stop |=> ##1 wait_frame)
    else $error("software trigger not a start");

  a_line1_start:
    assert property (state == ST_WAIT_ACQ && gate_on && !gate_rise
                     && ctrl.src == SRC_LINE1 && line1_pulse
                     && !cmd.acq_stop |=> state == ST_WAIT_FRAME)
    else $error("line 1 edge not a start");

  a_edge_polarity:
    assert property (line1_pulse |-> (ctrl.act_fall
                     ? $fell(u_line1.sync) : $rose(u_line1.sync)))
    else $error("wrong line edge taken");

  a_src_default:
    assert property (!wrote_ctrl |-> ctrl.src == SRC_LINE2
                     && !ctrl.std_mode)
    else $error("reset source or mode wrong");

  a_count_range:
    assert property (fcount != 8'h00)
    else $error("burst length left legal range");

  a_ignore_start:
    assert property (state == ST_WAIT_FRAME && acq_trig && !frame_acc
                     && !gate_rise && !cmd.acq_stop
                     |=> state == ST_WAIT_FRAME)
    else $error("start trigger acted outside wait");

  // line 2 is the reset source, so its edge must start a burst as well
  a_line2_start:
    assert property (state == ST_WAIT_ACQ && gate_on && !gate_rise
                     && ctrl.src == SRC_LINE2 && line2_pulse
                     && !cmd.acq_stop |=> state == ST_WAIT_FRAME)
    else $error("line 2 edge not a start");

  // source code 3 selects nothing; the gate must then keep waiting
  a_no_source:
    assert property (state == ST_WAIT_ACQ && gate_on
                     && ctrl.src == 2'h3 && !cmd.acq_stop
                     |=> state == ST_WAIT_ACQ)
    else $error("start taken with no source selected");

  a_idle_discard:
    assert property (state == ST_IDLE && frame_trig_in
                     |=> !frame_start_ok)
    else $error("frame passed before arming");

  a_stop_idle:
    assert property (cmd.acq_stop |=> state == ST_IDLE
                     ##1 (!wait_acq && !wait_frame))
    else $error("stop did not disarm the gate");

  a_bus_answer:
    assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not after one wait");

endmodule : astg_gate

`default_nettype wire

/* rtl/astg_regs.svh */
// Purpose: register offsets, field positions and reset values
// Assumes: 32-bit Avalon-MM data, byte addresses
// Notes:   definitions only
`ifndef ASTG_REGS_SVH
`define ASTG_REGS_SVH

`define ASTG_ADDR_W        4
`define ASTG_OFS_CTRL      4'h0
`define ASTG_OFS_FCOUNT    4'h4
`define ASTG_OFS_CMD       4'h8
`define ASTG_OFS_STATUS    4'hc

// control fields
`define ASTG_CTRL_STD      0
`define ASTG_CTRL_TRIG_ON  1
`define ASTG_CTRL_FALL     2
`define ASTG_CTRL_SRC_LO   4
`define ASTG_CTRL_SRC_HI   5

// command fields, write one to fire
`define ASTG_CMD_SWTRIG    0
`define ASTG_CMD_START     1
`define ASTG_CMD_STOP      2

// status fields
`define ASTG_STAT_WAIT_ACQ 0
`define ASTG_STAT_WAIT_FRM 1
`define ASTG_STAT_ARMED    2
`define ASTG_STAT_CNT_LO   8
`define ASTG_STAT_CNT_HI   15

// reset value and lowest accepted burst length
`define ASTG_FCOUNT_RST    8'h01
`define ASTG_FCOUNT_MIN    8'h01

`endif

/* rtl/astg_pkg.sv */
// Purpose: shared types of the acquisition start trigger gate
// Assumes: nothing beyond SystemVerilog packages
// Notes:   numeric constants live in astg_regs.svh
`default_nettype none

package astg_pkg;

  // gate status
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_ACQ,
    ST_WAIT_FRAME
  } astg_state_t;

  // start trigger source, codes are the register field encoding
  typedef enum logic [1:0] {
    SRC_SOFTWARE = 2'h0,
    SRC_LINE1    = 2'h1,
    SRC_LINE2    = 2'h2
  } astg_src_t;

  // control register image
  typedef struct packed {
    astg_src_t src;
    logic      act_fall;
    logic      trig_on;
    logic      std_mode;
  } astg_ctrl_t;

  // one-cycle command strobes
  typedef struct packed {
    logic sw_trig;
    logic acq_start;
    logic acq_stop;
  } astg_cmd_t;

endpackage : astg_pkg

`default_nettype wire

/* rtl/astg_edge_det.sv */
// Purpose: synchronise a trigger line and pick out one edge
// Assumes: line may be asynchronous to sys_clk
// Notes:   pulse comes two edges after the line moves
`timescale 1ns/100ps
`default_nettype none

module astg_edge_det (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic line_in,
  input  wire logic fall_sel,
  output logic      edge_pulse
);

  logic meta;
  logic sync;
  logic last;

  // two-flop synchroniser, meta feeds only sync
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= line_in;
      sync <= meta;
      last <= sync;
    end
  end

  // selected edge as a single-cycle pulse
  assign edge_pulse = fall_sel ? (last & ~sync) : (sync & ~last);

endmodule : astg_edge_det

`default_nettype wire

/* test/astg_line_src.sv */
// Purpose: far-side model of the two external trigger lines
// Assumes: lines idle low through a pull-down at the connector
// Notes:   each level is held long enough to cross the synchroniser
`timescale 1ns/100ps
`default_nettype none

module astg_line_src (
  input  wire logic sys_clk,
  output logic      line1_in,
  output logic      line2_in
);
  // pull-down level until the first drive
  initial begin
    line1_in = 1'b0;
    line2_in = 1'b0;
  end

  // move one line just after an edge, then hold it for eight cycles
  // so a slow synchroniser cannot miss it; either edge can be made
  task automatic drive(input int sel, input logic v);
    @(posedge sys_clk);
    if (sel == 1) begin
      line1_in <= v;
    end else begin
      line2_in <= v;
    end
    repeat (8) @(posedge sys_clk);
  endtask : drive
endmodule : astg_line_src

`default_nettype wire

/* test/testbench.sv */
// Purpose: self-checking bench for the start trigger gate
// Assumes: register access answers after one wait state or more
// Notes:   line edges come from the far-side model instance far
`timescale 1ns/100ps
`default_nettype none

`include "astg_regs.svh"

module testbench;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        line1_in;
  logic        line2_in;
  logic        frame_trig_in = 1'b0;
  logic        frame_start_ok;
  logic        wait_acq;
  logic        wait_frame;
  int          fails = 0;
  int          checks = 0;

  // 100 MHz system clock
  always #5 sys_clk = ~sys_clk;

  astg_gate uut (
    .sys_clk        (sys_clk),
    .rst_n          (rst_n),
    .avs_address    (avs_address),
    .avs_read       (avs_read),
    .avs_write      (avs_write),
    .avs_writedata  (avs_writedata),
    .avs_byteenable (avs_byteenable),
    .avs_readdata   (avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .line1_in       (line1_in),
    .line2_in       (line2_in),
    .frame_trig_in  (frame_trig_in),
    .frame_start_ok (frame_start_ok),
    .wait_acq       (wait_acq),
    .wait_frame     (wait_frame)
  );

  astg_line_src far (
    .sys_clk (sys_clk),
    .line1_in(line1_in),
    .line2_in(line2_in)
  );

  // verdict and end of run, shared with the watchdog
  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one Avalon cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    if (avs_waitrequest !== 1'b0) chk(32'h1, 32'h0);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    // an idle edge keeps the next request from reusing this time step
    @(posedge sys_clk);
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd

  // one-cycle frame request; accepted pulse shows one cycle later
  task automatic frame(input logic exp_ok);
    frame_trig_in <= 1'b1;
    @(posedge sys_clk);
    frame_trig_in <= 1'b0;
    @(posedge sys_clk);
    chk({31'h0, frame_start_ok}, {31'h0, exp_ok});
  endtask : frame

  // status outputs lag the state, so let them settle first
  task automatic state(input logic acq, input logic frm);
    repeat (3) @(posedge sys_clk);
    chk({30'h0, wait_acq, wait_frame}, {30'h0, acq, frm});
  endtask : state

  task automatic t_reset();
    rd(`ASTG_OFS_CTRL, 32'h20);
    rd(`ASTG_OFS_FCOUNT, 32'h1);
    rd(`ASTG_OFS_STATUS, 32'h0);
    rd(`ASTG_OFS_CMD, 32'h0);
    rd(4'h2, 32'h0);
    frame(1'b0);
  endtask : t_reset

  // mode bit set but legacy control: no gating, no burst end
  task automatic t_legacy();
    wr(`ASTG_OFS_CTRL, 32'h02);
    wr(`ASTG_OFS_CMD, 32'h2);
    state(1'b0, 1'b1);
    frame(1'b1);
    frame(1'b1);
    state(1'b0, 1'b1);
    wr(`ASTG_OFS_CMD, 32'h4);
    state(1'b0, 1'b0);
  endtask : t_legacy

  task automatic t_soft();
    wr(`ASTG_OFS_FCOUNT, 32'hff);
    rd(`ASTG_OFS_FCOUNT, 32'hff);
    wr(`ASTG_OFS_FCOUNT, 32'h3);
    wr(`ASTG_OFS_FCOUNT, 32'h0);
    rd(`ASTG_OFS_FCOUNT, 32'h3);
    wr(`ASTG_OFS_CTRL, 32'h03);
    wr(`ASTG_OFS_CMD, 32'h2);
    state(1'b1, 1'b0);
    frame(1'b0);
    wr(`ASTG_OFS_CMD, 32'h1);
    state(1'b0, 1'b1);
    frame(1'b1);
    frame(1'b1);
    rd(`ASTG_OFS_STATUS, 32'h206);
    wr(`ASTG_OFS_CMD, 32'h1);
    frame(1'b1);
    state(1'b1, 1'b0);
    frame(1'b0);
    rd(`ASTG_OFS_STATUS, 32'h5);
  endtask : t_soft

  task automatic t_line();
    wr(`ASTG_OFS_FCOUNT, 32'h1);
    wr(`ASTG_OFS_CTRL, 32'h13);
    far.drive(2, 1'b1);
    state(1'b1, 1'b0);
    far.drive(1, 1'b1);
    state(1'b0, 1'b1);
    frame(1'b1);
    state(1'b1, 1'b0);
    far.drive(1, 1'b0);
    state(1'b1, 1'b0);
    wr(`ASTG_OFS_CTRL, 32'h17);
    far.drive(1, 1'b1);
    state(1'b1, 1'b0);
    far.drive(1, 1'b0);
    state(1'b0, 1'b1);
    frame(1'b1);
    // line 2 as source: only its selected edge starts a burst
    wr(`ASTG_OFS_CTRL, 32'h23);
    far.drive(2, 1'b0);
    state(1'b1, 1'b0);
    far.drive(2, 1'b1);
    state(1'b0, 1'b1);
    frame(1'b1);
    state(1'b1, 1'b0);
    // source code 3: neither command nor line edge may start
    wr(`ASTG_OFS_CTRL, 32'h33);
    wr(`ASTG_OFS_CMD, 32'h1);
    far.drive(1, 1'b1);
    state(1'b1, 1'b0);
  endtask : t_line

  // mode off: start made inside, no return after the burst length
  task automatic t_off();
    wr(`ASTG_OFS_CTRL, 32'h01);
    state(1'b0, 1'b1);
    frame(1'b1);
    frame(1'b1);
    state(1'b0, 1'b1);
    // gate switched on while frames pass: back to start wait
    wr(`ASTG_OFS_CTRL, 32'h03);
    state(1'b1, 1'b0);
    frame(1'b0);
    wr(`ASTG_OFS_CMD, 32'h4);
    state(1'b0, 1'b0);
  endtask : t_off

  // main sequence after six cycles of reset
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_legacy();
    t_soft();
    t_line();
    t_off();
    complete_run();
  end

  // the run needs well under a thousand cycles; allow twenty thousand
  initial begin
    #200000;
    fails++;
    complete_run();
  end
endmodule : testbench

`default_nettype wire
